// *** port_flags_pkg.sv ***
// Constants, register map and timing for the root port change flags block
package port_flags_pkg;

	// ****************************************************
	// Register offsets
	// ****************************************************
	localparam logic [7:0]  OFF_PORT_STATUS = 8'h00;
	localparam logic [7:0]  OFF_IRQ_STATUS  = 8'h04;
	localparam logic [7:0]  OFF_IRQ_MASK    = 8'h08;
	localparam logic [7:0]  OFF_CONTROL     = 8'h0C;

	// ****************************************************
	// Field positions
	// ****************************************************
	localparam int BIT_RESET_DONE   = 20;
	localparam int BIT_OC_CHANGE    = 19;
	localparam int BIT_RESUME_DONE  = 18;
	localparam int BIT_ENABLE_CHG   = 17;
	localparam int BIT_CONNECT_CHG  = 16;
	localparam int BIT_RESET_ACTIVE = 4;
	localparam int BIT_OC_INDICATOR = 3;
	localparam int BIT_SUSPEND      = 2;
	localparam int BIT_PORT_ENABLED = 1;
	localparam int BIT_CCS          = 0;
	localparam int EV_ENABLE        = 0;
	localparam int EV_RESUME        = 1;
	localparam int EV_OC            = 2;
	localparam int EV_RESET         = 3;
	localparam int CTL_PER_PORT_OC  = 0;
	localparam int CTL_START_RESET  = 1;
	localparam int CTL_START_RESUME = 2;

	// ****************************************************
	// Reset values
	// ****************************************************
	localparam logic [3:0]  EV_RESET_VAL    = 4'h0;
	localparam logic [3:0]  MASK_RESET_VAL  = 4'h0;
	localparam logic [31:0] RDATA_RESET_VAL = 32'h0000_0000;

	// ****************************************************
	// Timing
	// ****************************************************
	localparam int CLK_PERIOD_NS    = 50;
	localparam int RESET_TIME_NS    = 10000000;
	localparam int RESUME_TIME_NS   = 20000000;
	localparam int EOP_TIME_NS      = 1334;
	localparam int RESYNC_TIME_NS   = 3000000;
	localparam logic [19:0] RESET_CYC  = 20'((RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [19:0] RESUME_CYC = 20'((RESUME_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [19:0] EOP_CYC    = 20'((EOP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [19:0] RESYNC_CYC = 20'((RESYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ****************************************************
	// Resume sequencer states, Gray along the path
	// ****************************************************
	typedef enum logic [1:0] {
		ST_IDLE   = 2'h0,
		ST_DRIVE  = 2'h1,
		ST_EOP    = 2'h3,
		ST_RESYNC = 2'h2
	} resume_state_t;

endpackage

// *** change_flag.sv ***
// One sticky change flag with write-one-to-clear and set priority
`timescale 1ns/100ps
module change_flag
	import port_flags_pkg::*;
(
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic nrst,
	input  wire logic ce,
	// Flag control
	input  wire logic set_evt,
	input  wire logic clr_req,
	output logic      flag_ff
);

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			flag_ff <= 1'b0;
		end else if (ce) begin
			if (set_evt) begin
				flag_ff <= 1'b1;
			end else if (clr_req) begin
				flag_ff <= 1'b0;
			end
		end
	end

endmodule // change_flag

// *** interval_timer.sv ***
// Down counter that times one interval and pulses at its end
`timescale 1ns/100ps
module interval_timer
	import port_flags_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic        ce,
	// Control
	input  wire logic        start,
	input  wire logic [19:0] load,
	input  wire logic        abort,
	// Status
	output logic             busy_ff,
	output logic             done_ff
);

	logic [19:0] cnt_ff;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_ff  <= 20'h00000;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end else if (ce) begin
			done_ff <= 1'b0;
			if (abort) begin
				busy_ff <= 1'b0;
			end else if (start) begin
				cnt_ff  <= load;
				busy_ff <= 1'b1;
			end else if (busy_ff) begin
				if (cnt_ff <= 20'h00001) begin
					busy_ff <= 1'b0;
					done_ff <= 1'b1;
				end else begin
					cnt_ff <= cnt_ff - 20'h00001;
				end
			end
		end
	end

endmodule // interval_timer

// *** root_port_change_flags.sv ***
// Root port status register with change flags, port timers and interrupt
`timescale 1ns/100ps
module root_port_change_flags
	import port_flags_pkg::*;
#(
	parameter logic [19:0] RESET_CYCLES  = RESET_CYC,
	parameter logic [19:0] RESUME_CYCLES = RESUME_CYC,
	parameter logic [19:0] RESYNC_CYCLES = RESYNC_CYC
)(
	// Clock, reset and enable
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic        ce,
	// Register port
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic [31:0]      rdata_ff,
	// Port state inputs
	input  wire logic        connect_status,
	input  wire logic        port_enabled_status,
	input  wire logic        port_overcurrent_indicator,
	input  wire logic        enable_hw_clear,
	// Port signalling outputs
	output logic             reset_drive_ff,
	output logic             resume_drive_ff,
	output logic             eop_drive_ff,
	// Interrupt
	output logic             irq_ff
);

	// ****************************************************
	// Declarations
	// ****************************************************
	logic          reset_done_flag;
	logic          overcurrent_change_flag;
	logic          resume_done_flag;
	logic          enable_change_flag;
	logic          per_port_oc_ff;
	logic          oc_ind_q_ff;
	logic [3:0]    ev_status_ff;
	logic [3:0]    ev_mask_ff;
	resume_state_t res_state_ff;
	resume_state_t nxt_res_state;
	logic          rst_start;
	logic          rst_busy;
	logic          rst_done;
	logic          res_start;
	logic [19:0]   res_load;
	logic          res_busy;
	logic          res_done;
	logic          resume_event;
	logic          oc_event;
	logic          wr_port;
	logic          wr_ctl;
	logic [3:0]    events;
	logic [3:0]    ev_clear;
	logic [31:0]   port_word;

	// ****************************************************
	// Decode
	// ****************************************************
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	assign wr_port = wr && hit(addr, OFF_PORT_STATUS);
	assign wr_ctl  = wr && hit(addr, OFF_CONTROL);

	// ****************************************************
	// Control register
	// ****************************************************
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			per_port_oc_ff <= 1'b0;
		end else if (ce && wr_ctl) begin
			per_port_oc_ff <= wdata[CTL_PER_PORT_OC];
		end
	end

	// ****************************************************
	// Port reset timing
	// ****************************************************
	assign rst_start = wr_ctl && wdata[CTL_START_RESET] && !rst_busy && (res_state_ff == ST_IDLE);

	interval_timer u_reset_timer (
		.core_clk (core_clk),
		.nrst     (nrst),
		.ce       (ce),
		.start    (rst_start),
		.load     (RESET_CYCLES),
		.abort    (1'b0),
		.busy_ff  (rst_busy),
		.done_ff  (rst_done)
	);

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			reset_drive_ff <= 1'b0;
		end else if (ce) begin
			reset_drive_ff <= rst_start || (rst_busy && !(rst_done));
		end
	end

	// ****************************************************
	// Resume sequencer
	// ****************************************************
	always_comb begin
		nxt_res_state = res_state_ff;
		res_start     = 1'b0;
		res_load      = RESUME_CYCLES;
		case (res_state_ff)
			ST_IDLE: begin
				if (wr_ctl && wdata[CTL_START_RESUME] && !rst_busy && !wdata[CTL_START_RESET]) begin
					nxt_res_state = ST_DRIVE;
					res_start     = 1'b1;
					res_load      = RESUME_CYCLES;
				end
			end
			ST_DRIVE: begin
				if (res_done) begin
					nxt_res_state = ST_EOP;
					res_start     = 1'b1;
					res_load      = EOP_CYC;
				end
			end
			ST_EOP: begin
				if (res_done) begin
					nxt_res_state = ST_RESYNC;
					res_start     = 1'b1;
					res_load      = RESYNC_CYCLES;
				end
			end
			ST_RESYNC: begin
				if (res_done) begin
					nxt_res_state = ST_IDLE;
				end
			end
			default: begin
				nxt_res_state = ST_IDLE;
			end
		endcase
	end

	interval_timer u_resume_timer (
		.core_clk (core_clk),
		.nrst     (nrst),
		.ce       (ce),
		.start    (res_start),
		.load     (res_load),
		.abort    (1'b0),
		.busy_ff  (res_busy),
		.done_ff  (res_done)
	);

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			res_state_ff <= ST_IDLE;
		end else if (ce) begin
			res_state_ff <= nxt_res_state;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			resume_drive_ff <= 1'b0;
			eop_drive_ff    <= 1'b0;
		end else if (ce) begin
			resume_drive_ff <= (nxt_res_state == ST_DRIVE);
			eop_drive_ff    <= (nxt_res_state == ST_EOP);
		end
	end

	assign resume_event = res_done && (res_state_ff == ST_RESYNC);

	// ****************************************************
	// Overcurrent change detect
	// ****************************************************
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			oc_ind_q_ff <= 1'b0;
		end else if (ce) begin
			oc_ind_q_ff <= port_overcurrent_indicator;
		end
	end

	// Only per-port reporting gives the flag meaning
	assign oc_event = per_port_oc_ff && (port_overcurrent_indicator != oc_ind_q_ff);

	// ****************************************************
	// Change flags
	// ****************************************************
	change_flag u_reset_done (
		.core_clk (core_clk),
		.nrst     (nrst),
		.ce       (ce),
		.set_evt  (rst_done),
		.clr_req  (wr_port && wdata[BIT_RESET_DONE]),
		.flag_ff  (reset_done_flag)
	);

	change_flag u_oc_change (
		.core_clk (core_clk),
		.nrst     (nrst),
		.ce       (ce),
		.set_evt  (oc_event),
		.clr_req  (wr_port && wdata[BIT_OC_CHANGE]),
		.flag_ff  (overcurrent_change_flag)
	);

	change_flag u_resume_done (
		.core_clk (core_clk),
		.nrst     (nrst),
		.ce       (ce),
		.set_evt  (resume_event),
		.clr_req  ((wr_port && wdata[BIT_RESUME_DONE]) || rst_done),
		.flag_ff  (resume_done_flag)
	);

	change_flag u_enable_change (
		.core_clk (core_clk),
		.nrst     (nrst),
		.ce       (ce),
		.set_evt  (enable_hw_clear),
		.clr_req  (wr_port && wdata[BIT_ENABLE_CHG]),
		.flag_ff  (enable_change_flag)
	);

	// ****************************************************
	// Interrupt status and mask
	// ****************************************************
	assign events   = {rst_done, oc_event, resume_event, enable_hw_clear};
	assign ev_clear = (rd && hit(addr, OFF_IRQ_STATUS)) ? 4'hF : 4'h0;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ev_status_ff <= EV_RESET_VAL;
		end else if (ce) begin
			ev_status_ff <= events | (ev_status_ff & ~ev_clear);
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ev_mask_ff <= MASK_RESET_VAL;
		end else if (ce && wr && hit(addr, OFF_IRQ_MASK)) begin
			ev_mask_ff <= wdata[3:0];
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			irq_ff <= 1'b0;
		end else if (ce) begin
			irq_ff <= |((events | (ev_status_ff & ~ev_clear)) & ev_mask_ff);
		end
	end

	// ****************************************************
	// Read data
	// ****************************************************
	always_comb begin
		port_word                   = 32'h0000_0000;
		port_word[BIT_RESET_DONE]   = reset_done_flag;
		port_word[BIT_OC_CHANGE]    = overcurrent_change_flag;
		port_word[BIT_RESUME_DONE]  = resume_done_flag;
		port_word[BIT_ENABLE_CHG]   = enable_change_flag;
		port_word[BIT_RESET_ACTIVE] = rst_busy;
		port_word[BIT_OC_INDICATOR] = port_overcurrent_indicator;
		port_word[BIT_SUSPEND]      = (res_state_ff != ST_IDLE);
		port_word[BIT_PORT_ENABLED] = port_enabled_status;
		port_word[BIT_CCS]          = connect_status;
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rdata_ff <= RDATA_RESET_VAL;
		end else if (ce) begin
			rdata_ff <= RDATA_RESET_VAL;
			if (rd) begin
				case (addr)
					OFF_PORT_STATUS: rdata_ff <= port_word;
					OFF_IRQ_STATUS:  rdata_ff <= {28'h0000000, ev_status_ff};
					OFF_IRQ_MASK:    rdata_ff <= {28'h0000000, ev_mask_ff};
					OFF_CONTROL:     rdata_ff <= {31'h00000000, per_port_oc_ff};
					default:         rdata_ff <= RDATA_RESET_VAL;
				endcase
			end
		end
	end

	// ****************************************************
	// Checks
	// ****************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	chk_reset_sets_flag: assert property (
		ce && rst_done |=> reset_done_flag
	) else $error("reset-done flag not set at end of port reset");

	chk_zero_write_keeps: assert property (
		ce && wr_port && !wdata[BIT_RESET_DONE] && reset_done_flag |=> reset_done_flag
	) else $error("write of zero disturbed reset-done flag");

	chk_one_write_clears: assert property (
		ce && wr_port && wdata[BIT_ENABLE_CHG] && !enable_hw_clear |=> !enable_change_flag
	) else $error("write of one did not clear enable-change flag");

	chk_oc_change_set: assert property (
		ce && per_port_oc_ff && (port_overcurrent_indicator != oc_ind_q_ff) |=> overcurrent_change_flag
	) else $error("overcurrent change not flagged");

	chk_oc_global_quiet: assert property (
		ce && !per_port_oc_ff && !overcurrent_change_flag |=> !overcurrent_change_flag
	) else $error("overcurrent-change flag set in global reporting");

	chk_resume_after_seq: assert property (
		$rose(resume_done_flag) |-> $past(res_state_ff) == ST_RESYNC && $past(res_done)
	) else $error("resume-done set before resync delay ended");

	chk_resume_order: assert property (
		ce && res_state_ff == ST_DRIVE && res_done |=> res_state_ff == ST_EOP ##0 res_busy
	) else $error("resume sequence skipped the end-of-packet phase");

	chk_resume_auto_clr: assert property (
		ce && rst_done && !resume_event |=> !resume_done_flag && reset_done_flag
	) else $error("resume-done not cleared when reset-done set");

	chk_enable_hw_set: assert property (
		ce && enable_hw_clear |=> enable_change_flag
	) else $error("hardware enable clear not flagged");

	chk_enable_sw_quiet: assert property (
		ce && !enable_hw_clear && !enable_change_flag |=> !enable_change_flag
	) else $error("enable-change flag set without hardware event");

	chk_reserved_zero: assert property (
		ce && rd && hit(addr, OFF_PORT_STATUS) |=> rdata_ff[31:21] == 11'h000 && !rdata_ff[BIT_CONNECT_CHG]
	) else $error("reserved upper bits of port status read nonzero");

	chk_set_wins_clear: assert property (
		ce && oc_event && wr_port && wdata[BIT_OC_CHANGE] |=> overcurrent_change_flag
	) else $error("same-cycle clear beat an overcurrent change");

endmodule // root_port_change_flags

// *** tb_top.sv ***
// Self-checking testbench for the root port change flags block
`timescale 1ns/100ps
module tb_top
	import port_flags_pkg::*;
;
	// ****************************************************
	// Signals
	// ****************************************************
	logic        core_clk;
	logic        nrst;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        wr;
	logic        rd;
	logic [31:0] rdata_ff;
	logic        ce;
	logic        ccs;
	logic        port_en;
	logic        oc_ind;
	logic        en_clr;
	logic        reset_drive_ff;
	logic        resume_drive_ff;
	logic        eop_drive_ff;
	logic        irq_ff;
	logic [3:0]  flg;
	logic [31:0] v;
	logic [31:0] r;
	int          mismatches;
	int          cmp_count;
	int          n;
	int          rst_cyc = 0;
	int          res_cyc = 0;
	int          eop_cyc = 0;

	localparam int T_RESET  = 20;
	localparam int T_RESUME = 40;
	localparam int T_RESYNC = 6;

	root_port_change_flags #(
		.RESET_CYCLES(20'(T_RESET)), .RESUME_CYCLES(20'(T_RESUME)), .RESYNC_CYCLES(20'(T_RESYNC))
	) i_dut (
		.core_clk(core_clk), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata_ff(rdata_ff), .connect_status(ccs), .port_enabled_status(port_en),
		.port_overcurrent_indicator(oc_ind), .enable_hw_clear(en_clr), .reset_drive_ff(reset_drive_ff),
		.resume_drive_ff(resume_drive_ff), .eop_drive_ff(eop_drive_ff), .irq_ff(irq_ff));

	always #25 core_clk = ~core_clk;

	// Counts the cycles each port signalling output stands high
	always @(negedge core_clk) begin
		if (reset_drive_ff === 1'b1) begin
			rst_cyc++;
		end
		if (resume_drive_ff === 1'b1) begin
			res_cyc++;
		end
		if (eop_drive_ff === 1'b1) begin
			eop_cyc++;
		end
	end

	// ****************************************************
	// Helpers
	// ****************************************************
	function automatic logic [31:0] port_word(input logic [3:0] f, input logic ra, input logic rs);
		port_word = {11'h000, f, 1'b0, 11'h000, ra, oc_ind, rs, port_en, ccs};
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask

	// Write with optional same-edge hardware enable clear and overcurrent toggle
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic pe, input logic tg);
		@(posedge core_clk);
		wr     <= 1'b1;
		addr   <= a;
		wdata  <= d;
		en_clr <= pe;
		if (tg) begin
			oc_ind <= ~oc_ind;
		end
		@(posedge core_clk);
		wr     <= 1'b0;
		en_clr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge core_clk);
		rd <= 1'b0;
		#1;
		d = rdata_ff;
	endtask

	task automatic wait_bit(input int b, output int cnt);
		v = 32'h0000_0000;
		for (cnt = 0; cnt < 200 && v[b] !== 1'b1; cnt++) begin
			rd_reg(OFF_PORT_STATUS, v);
		end
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		#1000000;
		mismatches++;
		tally_and_finish;
	end

	// ****************************************************
	// Main sequence
	// ****************************************************
	initial begin
		core_clk = 1'b0;
		nrst = 1'b0;
		{wr, rd, en_clr, ccs, port_en, oc_ind} = 6'h00;
		ce = 1'b1;
		addr = 8'h00;
		wdata = 32'h0000_0000;
		mismatches = 0;
		cmp_count = 0;
		void'($urandom(32'h58F4));
		repeat (8) @(posedge core_clk);
		nrst <= 1'b1;
		rd_reg(OFF_PORT_STATUS, v);
		chk("port reset", port_word(4'h0, 1'b0, 1'b0), v);
		rd_reg(OFF_IRQ_MASK, v);
		chk("mask reset", 32'h0000_0000, v);
		wr_reg(8'h10, 32'hFFFF_FFFF, 1'b0, 1'b1);
		rd_reg(8'h10, v);
		chk("unmapped", 32'h0000_0000, v);
		rd_reg(OFF_PORT_STATUS, v);
		chk("global oc", port_word(4'h0, 1'b0, 1'b0), v);
		wr_reg(OFF_CONTROL, 32'h0000_0001, 1'b0, 1'b0);
		rd_reg(OFF_CONTROL, v);
		chk("control", 32'h0000_0001, v);
		wr_reg(OFF_CONTROL, 32'h0000_0005, 1'b0, 1'b0);
		rd_reg(OFF_PORT_STATUS, v);
		chk("resume active", port_word(4'h0, 1'b0, 1'b1), v);
		wait_bit(BIT_RESUME_DONE, n);
		chk("resume long", 32'h1, 32'(n >= 36));
		rd_reg(OFF_PORT_STATUS, v);
		chk("resume done", port_word(4'h2, 1'b0, 1'b0), v);
		chk("resume drive cycles", 32'(T_RESUME + 1), 32'(res_cyc));
		chk("eop drive cycles", 32'(EOP_CYC) + 32'h1, 32'(eop_cyc));
		wr_reg(OFF_PORT_STATUS, 32'h0000_0000, 1'b0, 1'b0);
		rd_reg(OFF_PORT_STATUS, v);
		chk("write zero", port_word(4'h2, 1'b0, 1'b0), v);
		wr_reg(OFF_CONTROL, 32'h0000_0003, 1'b0, 1'b0);
		rd_reg(OFF_PORT_STATUS, v);
		chk("reset active", port_word(4'h2, 1'b1, 1'b0), v);
		chk("reset drive", 32'(reset_drive_ff), 32'h1);
		wait_bit(BIT_RESET_DONE, n);
		chk("reset long", 32'h1, 32'(n >= 9));
		chk("reset drive cycles", 32'(T_RESET + 1), 32'(rst_cyc));
		rd_reg(OFF_PORT_STATUS, v);
		chk("reset done", port_word(4'h8, 1'b0, 1'b0), v);
		wr_reg(OFF_PORT_STATUS, 32'h0010_0000, 1'b0, 1'b0);
		flg = 4'h0;
		// Random clears with hardware events on the same edge and free port inputs
		repeat (24) begin
			r = $urandom;
			@(posedge core_clk);
			ccs <= r[0];
			port_en <= r[1];
			wr_reg(OFF_PORT_STATUS, r & 32'h001E_0000, r[2], r[3]);
			flg = (flg & ~r[20:17]) | {1'b0, r[3], 1'b0, r[2]};
			rd_reg(OFF_PORT_STATUS, v);
			chk("random", port_word(flg, 1'b0, 1'b0), v);
		end
		rd_reg(OFF_IRQ_STATUS, v);
		wr_reg(OFF_IRQ_MASK, 32'h0000_0000, 1'b1, 1'b0);
		repeat (2) @(posedge core_clk);
		#1;
		chk("irq masked", 32'(irq_ff), 32'h0);
		wr_reg(OFF_IRQ_MASK, 32'h0000_000F, 1'b0, 1'b0);
		repeat (2) @(posedge core_clk);
		#1;
		chk("irq on", 32'(irq_ff), 32'h1);
		rd_reg(OFF_IRQ_STATUS, v);
		chk("event status", 32'h1 << EV_ENABLE, v);
		repeat (2) @(posedge core_clk);
		#1;
		chk("irq cleared", 32'(irq_ff), 32'h0);
		// Clock enable low must freeze the flags against a clearing write
		@(posedge core_clk);
		ce <= 1'b0;
		wr_reg(OFF_PORT_STATUS, 32'h001E_0000, 1'b0, 1'b0);
		ce <= 1'b1;
		rd_reg(OFF_PORT_STATUS, v);
		chk("ce freeze", port_word(flg | 4'h1, 1'b0, 1'b0), v);
		wr_reg(OFF_PORT_STATUS, 32'h001E_0000, 1'b0, 1'b0);
		rd_reg(OFF_PORT_STATUS, v);
		chk("clear all", port_word(4'h0, 1'b0, 1'b0), v);
		tally_and_finish;
	end

endmodule // tb_top
